// ### core/cfg_map_pkg.sv
// Constants, types and decode helpers of the configuration word mapper
// How it works
// [R01] Word 06h bit 15 sets interrupt pin request of ports 1 and 2.
// [R02] Word 0Ch bits 1:0 give maximum payload support of every port.
// [R03] Word 0Ch bits 3:2 give ASPM support level of every port.
// [R04] Word 0Ch bit 4 marks role based error reporting implemented.
// [R05] Word 0Ch bit 5 disables the MSI capability of every port.
// [R06] Word 0Ch bit 6 disables compliance pattern parity control.
// [R07] Word 0Ch bit 7 disables the power management capability.
// [R08] Word 0Ch bit 8 enables posted passing non-posted ordering.
// [R09] Word 0Ch bit 9 gives bandwidth notification on downstream ports.
// [R10] Word 0Ch bit 10 freezes the packet ordering feature.
// [R11] Word 0Ch bit 11 selects start-of-frame latency; zero is shorter.
// [R12] Word 0Ch bit 12 enables surprise down error reporting.
// [R13] Word 0Ch bit 13 makes power management data select writable.
// [R14] Word 0Ch bit 14 enables latency tolerance reporting.
// [R15] Word 0Ch bit 15 enables the 4KB boundary crossing check.
// [R16] Word 0Eh gives three 5-bit margin drive levels per port.
// [R17] Word 0Eh bit 15 enables buffer flush and fill capability.
// [R18] Word 10h bits 4:0 give nominal 3.5 dB drive level.
// [R19] Every port gets the same value except port 0 interrupt pin and bandwidth notification; ready only after loading ends.
package cfg_map_pkg;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int NUM_PORTS = 3;
    localparam int ADDR_W = 8;
    localparam int WORD_W = 16;
    localparam int MPS_W = 2;
    localparam int ASPM_W = 2;
    localparam int LVL_W = 5;

    // ----------------------------------------
    // Word addresses and defaults
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_INT_PIN = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_SUBSYS_VENDOR = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_SUBSYS = 8'h0a;
    localparam logic [ADDR_W-1:0] ADDR_CAPS = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_MARGIN = 8'h0e;
    localparam logic [ADDR_W-1:0] ADDR_NOMINAL = 8'h10;
    localparam logic [WORD_W-1:0] DEF_INT_PIN = 16'h0806;
    localparam logic [WORD_W-1:0] DEF_SUBSYS = 16'h0000;
    localparam logic [WORD_W-1:0] DEF_CAPS = 16'h001d;
    localparam logic [WORD_W-1:0] DEF_MARGIN = 16'h916b;
    localparam logic [WORD_W-1:0] DEF_NOMINAL = 16'h0a73;

    // ----------------------------------------
    // Field positions inside the words
    // ----------------------------------------
    localparam int INT_PIN_BIT = 15;
    localparam int CAPS_MPS_LSB = 0;
    localparam int CAPS_ASPM_LSB = 2;
    localparam int CAPS_RBER = 4;
    localparam int CAPS_MSI_DIS = 5;
    localparam int CAPS_PARITY_DIS = 6;
    localparam int CAPS_PM_DIS = 7;
    localparam int CAPS_RULE5 = 8;
    localparam int CAPS_LBN = 9;
    localparam int CAPS_FROZEN = 10;
    localparam int CAPS_SOF = 11;
    localparam int CAPS_SDOWN = 12;
    localparam int CAPS_PMDATA = 13;
    localparam int CAPS_LTR = 14;
    localparam int CAPS_BOUND = 15;
    localparam int MGN_3P5_LSB = 0;
    localparam int MGN_6DB_LSB = 5;
    localparam int MGN_HALF_LSB = 10;
    localparam int MGN_OBFF = 15;
    localparam int NOM_3P5_LSB = 0;

    typedef enum logic [1:0] {
        ST_LOADING = 2'b01,
        ST_READY = 2'b10
    } load_state_t;

    // True when an accepted word carries the given address
    function automatic logic word_hit(input logic accept,
                                      input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] target);
        word_hit = accept && (addr == target);
    endfunction

endpackage

// ### core/eeprom_config_word_mapper.sv
// Top of the EEPROM word to per-port configuration field mapper
`timescale 1ns/1ps
module eeprom_config_word_mapper #(
    parameter int NUM_PORTS = cfg_map_pkg::NUM_PORTS
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic WORD_VALID,
    input wire logic [cfg_map_pkg::ADDR_W-1:0] WORD_ADDR,
    input wire logic [cfg_map_pkg::WORD_W-1:0] WORD_DATA,
    input wire logic LOAD_DONE,
    output logic CFG_READY,
    output logic [cfg_map_pkg::WORD_W-1:0] SUBSYS_VENDOR_ID,
    output logic [cfg_map_pkg::WORD_W-1:0] SUBSYS_ID,
    output logic [NUM_PORTS-1:0] INT_PIN_REQ,
    output logic [NUM_PORTS*cfg_map_pkg::MPS_W-1:0] MAX_PAYLOAD,
    output logic [NUM_PORTS*cfg_map_pkg::ASPM_W-1:0] ASPM_SUPPORT,
    output logic [NUM_PORTS-1:0] ROLE_ERR_RPT,
    output logic [NUM_PORTS-1:0] MSI_DISABLE,
    output logic [NUM_PORTS-1:0] COMPL_PARITY_DISABLE,
    output logic [NUM_PORTS-1:0] PM_CAP_DISABLE,
    output logic [NUM_PORTS-1:0] POSTED_PASS_NONPOSTED_RULE,
    output logic [NUM_PORTS-1:0] LINK_BW_NOTIFY,
    output logic [NUM_PORTS-1:0] ORDER_FROZEN,
    output logic [NUM_PORTS-1:0] TX_SOF_LATENCY,
    output logic [NUM_PORTS-1:0] SURPRISE_DOWN_EN,
    output logic [NUM_PORTS-1:0] PM_DATA_SEL_RW,
    output logic [NUM_PORTS-1:0] LTR_EN,
    output logic [NUM_PORTS-1:0] BOUNDARY_4KB_CHECK,
    output logic [NUM_PORTS*cfg_map_pkg::LVL_W-1:0] MARGIN_DRIVE_LEVEL_3P5DB,
    output logic [NUM_PORTS*cfg_map_pkg::LVL_W-1:0] MARGIN_DRIVE_LEVEL_6DB,
    output logic [NUM_PORTS*cfg_map_pkg::LVL_W-1:0]
        MARGIN_DRIVE_LEVEL_HALF_SWING,
    output logic [NUM_PORTS-1:0] OBFF_EN,
    output logic [NUM_PORTS*cfg_map_pkg::LVL_W-1:0] NOMINAL_DRIVE_LEVEL_3P5DB
);
    logic accept;
    logic [cfg_map_pkg::WORD_W-1:0] caps [NUM_PORTS];
    logic [cfg_map_pkg::WORD_W-1:0] margin [NUM_PORTS];

    // ----------------------------------------
    // Load sequencing
    // ----------------------------------------
    load_sequencer u_seq (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .word_valid(WORD_VALID),
        .load_done(LOAD_DONE),
        .accept(accept),
        .ready_q(CFG_READY)
    );

    // ----------------------------------------
    // Shared subsystem identifiers
    // ----------------------------------------
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SUBSYS_VENDOR_ID <= cfg_map_pkg::DEF_SUBSYS;
        end else if (cfg_map_pkg::word_hit(accept, WORD_ADDR,
                     cfg_map_pkg::ADDR_SUBSYS_VENDOR)) begin
            SUBSYS_VENDOR_ID <= WORD_DATA;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            SUBSYS_ID <= cfg_map_pkg::DEF_SUBSYS;
        end else if (cfg_map_pkg::word_hit(accept, WORD_ADDR,
                     cfg_map_pkg::ADDR_SUBSYS)) begin
            SUBSYS_ID <= WORD_DATA;
        end
    end

    // ----------------------------------------
    // Per-port field copies
    // ----------------------------------------
    for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
        port_cfg_slice #(
            .PORT_INDEX(g)
        ) u_slice (
            .clk(SYS_CLK),
            .rstn(RSTN),
            .accept(accept),
            .addr(WORD_ADDR),
            .data(WORD_DATA),
            .int_pin_q(INT_PIN_REQ[g]),
            .lbn_q(LINK_BW_NOTIFY[g]),
            .caps_q(caps[g]),
            .margin_q(margin[g]),
            .nominal_q(NOMINAL_DRIVE_LEVEL_3P5DB[g*cfg_map_pkg::LVL_W +:
                                                 cfg_map_pkg::LVL_W])
        );
        // Field split of the held words
        assign MAX_PAYLOAD[g*cfg_map_pkg::MPS_W +: cfg_map_pkg::MPS_W] =
            caps[g][cfg_map_pkg::CAPS_MPS_LSB +: cfg_map_pkg::MPS_W]; // [R02]
        assign ASPM_SUPPORT[g*cfg_map_pkg::ASPM_W +: cfg_map_pkg::ASPM_W] =
            caps[g][cfg_map_pkg::CAPS_ASPM_LSB +: cfg_map_pkg::ASPM_W]; // [R03]
        assign ROLE_ERR_RPT[g] = caps[g][cfg_map_pkg::CAPS_RBER]; // [R04]
        assign MSI_DISABLE[g] = caps[g][cfg_map_pkg::CAPS_MSI_DIS]; // [R05]
        assign COMPL_PARITY_DISABLE[g] =
            caps[g][cfg_map_pkg::CAPS_PARITY_DIS]; // [R06]
        assign PM_CAP_DISABLE[g] = caps[g][cfg_map_pkg::CAPS_PM_DIS]; // [R07]
        assign POSTED_PASS_NONPOSTED_RULE[g] =
            caps[g][cfg_map_pkg::CAPS_RULE5]; // [R08]
        assign ORDER_FROZEN[g] = caps[g][cfg_map_pkg::CAPS_FROZEN]; // [R10]
        assign TX_SOF_LATENCY[g] = caps[g][cfg_map_pkg::CAPS_SOF]; // [R11]
        assign SURPRISE_DOWN_EN[g] = caps[g][cfg_map_pkg::CAPS_SDOWN]; // [R12]
        assign PM_DATA_SEL_RW[g] = caps[g][cfg_map_pkg::CAPS_PMDATA]; // [R13]
        assign LTR_EN[g] = caps[g][cfg_map_pkg::CAPS_LTR]; // [R14]
        assign BOUNDARY_4KB_CHECK[g] =
            caps[g][cfg_map_pkg::CAPS_BOUND]; // [R15]
        assign MARGIN_DRIVE_LEVEL_3P5DB[g*cfg_map_pkg::LVL_W +:
                                        cfg_map_pkg::LVL_W] =
            margin[g][cfg_map_pkg::MGN_3P5_LSB +: cfg_map_pkg::LVL_W]; // [R16]
        assign MARGIN_DRIVE_LEVEL_6DB[g*cfg_map_pkg::LVL_W +:
                                      cfg_map_pkg::LVL_W] =
            margin[g][cfg_map_pkg::MGN_6DB_LSB +: cfg_map_pkg::LVL_W]; // [R16]
        assign MARGIN_DRIVE_LEVEL_HALF_SWING[g*cfg_map_pkg::LVL_W +:
                                             cfg_map_pkg::LVL_W] =
            margin[g][cfg_map_pkg::MGN_HALF_LSB +: cfg_map_pkg::LVL_W]; // [R16]
        assign OBFF_EN[g] = margin[g][cfg_map_pkg::MGN_OBFF]; // [R17]
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RSTN);

    logic hit_int;
    logic hit_caps;
    logic hit_mgn;
    logic hit_nom;
    assign hit_int = cfg_map_pkg::word_hit(accept, WORD_ADDR,
                                           cfg_map_pkg::ADDR_INT_PIN);
    assign hit_caps = cfg_map_pkg::word_hit(accept, WORD_ADDR,
                                            cfg_map_pkg::ADDR_CAPS);
    assign hit_mgn = cfg_map_pkg::word_hit(accept, WORD_ADDR,
                                           cfg_map_pkg::ADDR_MARGIN);
    assign hit_nom = cfg_map_pkg::word_hit(accept, WORD_ADDR,
                                           cfg_map_pkg::ADDR_NOMINAL);

    int_pin_load_a: assert property ( // [R01]
        hit_int |=> INT_PIN_REQ ==
            {{(NUM_PORTS-1){$past(WORD_DATA[cfg_map_pkg::INT_PIN_BIT])}},
             1'b0})
        else $error("interrupt pin request not loaded");

    payload_load_a: assert property ( // [R02]
        hit_caps |=> MAX_PAYLOAD ==
            {NUM_PORTS{$past(WORD_DATA[1:0])}})
        else $error("max payload support not loaded");

    aspm_load_a: assert property ( // [R03]
        hit_caps |=> ASPM_SUPPORT == {NUM_PORTS{$past(WORD_DATA[3:2])}})
        else $error("aspm support not loaded");

    cap_flags_a: assert property ( // [R04]
        hit_caps |=>
            ROLE_ERR_RPT == {NUM_PORTS{$past(WORD_DATA[4])}} &&
            MSI_DISABLE == {NUM_PORTS{$past(WORD_DATA[5])}} && // [R05]
            COMPL_PARITY_DISABLE == {NUM_PORTS{$past(WORD_DATA[6])}} &&
            PM_CAP_DISABLE == {NUM_PORTS{$past(WORD_DATA[7])}})
        else $error("capability flags not loaded");

    order_flags_a: assert property ( // [R08]
        hit_caps |=>
            POSTED_PASS_NONPOSTED_RULE == {NUM_PORTS{$past(WORD_DATA[8])}} &&
            ORDER_FROZEN == {NUM_PORTS{$past(WORD_DATA[10])}} &&
            TX_SOF_LATENCY == {NUM_PORTS{$past(WORD_DATA[11])}})
        else $error("ordering controls not loaded");

    bw_notify_a: assert property ( // [R09]
        hit_caps |=> LINK_BW_NOTIFY ==
            {{(NUM_PORTS-1){$past(WORD_DATA[9])}}, 1'b0})
        else $error("bandwidth notification not loaded");

    upper_caps_a: assert property ( // [R12]
        hit_caps |=>
            SURPRISE_DOWN_EN == {NUM_PORTS{$past(WORD_DATA[12])}} &&
            PM_DATA_SEL_RW == {NUM_PORTS{$past(WORD_DATA[13])}} &&
            LTR_EN == {NUM_PORTS{$past(WORD_DATA[14])}} &&
            BOUNDARY_4KB_CHECK == {NUM_PORTS{$past(WORD_DATA[15])}})
        else $error("upper capability bits not loaded");

    margin_load_a: assert property ( // [R16]
        hit_mgn |=>
            MARGIN_DRIVE_LEVEL_3P5DB == {NUM_PORTS{$past(WORD_DATA[4:0])}} &&
            MARGIN_DRIVE_LEVEL_6DB == {NUM_PORTS{$past(WORD_DATA[9:5])}} &&
            MARGIN_DRIVE_LEVEL_HALF_SWING ==
                {NUM_PORTS{$past(WORD_DATA[14:10])}})
        else $error("margin drive levels not loaded");

    obff_load_a: assert property ( // [R17]
        hit_mgn |=> OBFF_EN == {NUM_PORTS{$past(WORD_DATA[15])}})
        else $error("buffer flush enable not loaded");

    nominal_load_a: assert property ( // [R18]
        hit_nom |=> NOMINAL_DRIVE_LEVEL_3P5DB ==
            {NUM_PORTS{$past(WORD_DATA[4:0])}})
        else $error("nominal drive level not loaded");

    fields_hold_a: assert property ( // [R19]
        !accept |=> $stable(MAX_PAYLOAD) && $stable(MARGIN_DRIVE_LEVEL_6DB) &&
            $stable(NOMINAL_DRIVE_LEVEL_3P5DB) && $stable(INT_PIN_REQ))
        else $error("fields changed without a loaded word");

    ready_timing_a: assert property ( // [R19]
        !CFG_READY && LOAD_DONE |=> CFG_READY)
        else $error("ready did not follow end of load");

    ready_cause_a: assert property ( // [R19]
        $rose(CFG_READY) |-> $past(LOAD_DONE))
        else $error("ready rose without end of load");

    no_late_load_a: assert property ( // [R19]
        CFG_READY |-> !accept ##1 CFG_READY)
        else $error("word taken after loading ended");

    caps_load_c: cover property (hit_caps ##[1:40] CFG_READY);
    margin_load_c: cover property (hit_mgn ##[1:20] hit_nom);
    ready_c: cover property (hit_int ##[1:40] $rose(CFG_READY));
    late_word_c: cover property (CFG_READY && WORD_VALID);
endmodule

// ### core/load_sequencer.sv
// Load phase sequencer: accepts words until the load ends
`timescale 1ns/1ps
module load_sequencer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic word_valid,
    input wire logic load_done,
    output logic accept,
    output logic ready_q
);
    cfg_map_pkg::load_state_t state_q;

    // Words are taken only while loading, so late words cannot alter setup
    assign accept = word_valid && (state_q == cfg_map_pkg::ST_LOADING);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= cfg_map_pkg::ST_LOADING;
        end else begin
            case (state_q)
                cfg_map_pkg::ST_LOADING: begin
                    if (load_done) begin
                        state_q <= cfg_map_pkg::ST_READY; // [R19]
                    end
                end
                cfg_map_pkg::ST_READY: begin
                    state_q <= cfg_map_pkg::ST_READY;
                end
                default: begin
                    state_q <= cfg_map_pkg::ST_LOADING;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ready_q <= 1'b0;
        end else if (state_q == cfg_map_pkg::ST_LOADING && load_done) begin
            ready_q <= 1'b1; // [R19]
        end
    end
endmodule

// ### core/port_cfg_slice.sv
// Per-port copy of the loaded configuration fields
`timescale 1ns/1ps
module port_cfg_slice #(
    parameter int PORT_INDEX = 0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic accept,
    input wire logic [cfg_map_pkg::ADDR_W-1:0] addr,
    input wire logic [cfg_map_pkg::WORD_W-1:0] data,
    output logic int_pin_q,
    output logic lbn_q,
    output logic [cfg_map_pkg::WORD_W-1:0] caps_q,
    output logic [cfg_map_pkg::WORD_W-1:0] margin_q,
    output logic [cfg_map_pkg::LVL_W-1:0] nominal_q
);
    // Upstream port 0 has neither interrupt pin nor bandwidth notification
    localparam logic DOWNSTREAM = (PORT_INDEX != 0);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            int_pin_q <= cfg_map_pkg::DEF_INT_PIN[cfg_map_pkg::INT_PIN_BIT];
        end else if (cfg_map_pkg::word_hit(accept, addr,
                                           cfg_map_pkg::ADDR_INT_PIN)) begin
            int_pin_q <= DOWNSTREAM && data[cfg_map_pkg::INT_PIN_BIT]; // [R01]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            caps_q <= cfg_map_pkg::DEF_CAPS;
            lbn_q <= 1'b0;
        end else if (cfg_map_pkg::word_hit(accept, addr,
                                           cfg_map_pkg::ADDR_CAPS)) begin
            caps_q <= data; // [R19]
            lbn_q <= DOWNSTREAM && data[cfg_map_pkg::CAPS_LBN]; // [R09]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            margin_q <= cfg_map_pkg::DEF_MARGIN;
        end else if (cfg_map_pkg::word_hit(accept, addr,
                                           cfg_map_pkg::ADDR_MARGIN)) begin
            margin_q <= data; // [R16]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            nominal_q <= cfg_map_pkg::DEF_NOMINAL[cfg_map_pkg::LVL_W-1:0];
        end else if (cfg_map_pkg::word_hit(accept, addr,
                                           cfg_map_pkg::ADDR_NOMINAL)) begin
            nominal_q <= data[cfg_map_pkg::NOM_3P5_LSB +:
                              cfg_map_pkg::LVL_W]; // [R18]
        end
    end
endmodule

// ### sim/eeprom_config_word_mapper_tb.sv
// Self-checking bench of the configuration word mapper
`timescale 1ns/1ps
module eeprom_config_word_mapper_tb;
    // ----------------------------------------
    // Clock, reset and design hookup
    // ----------------------------------------
    logic SYS_CLK = 1'b0;
    logic RSTN = 1'b0;
    logic WORD_VALID, LOAD_DONE, CFG_READY;
    logic [7:0] WORD_ADDR;
    logic [15:0] WORD_DATA, SUBSYS_VENDOR_ID, SUBSYS_ID;
    logic [2:0] INT_PIN_REQ, ROLE_ERR_RPT, MSI_DISABLE, COMPL_PARITY_DISABLE;
    logic [2:0] PM_CAP_DISABLE, POSTED_PASS_NONPOSTED_RULE, LINK_BW_NOTIFY;
    logic [2:0] ORDER_FROZEN, TX_SOF_LATENCY, SURPRISE_DOWN_EN;
    logic [2:0] PM_DATA_SEL_RW, LTR_EN, BOUNDARY_4KB_CHECK, OBFF_EN;
    logic [5:0] MAX_PAYLOAD, ASPM_SUPPORT;
    logic [14:0] MARGIN_DRIVE_LEVEL_3P5DB, MARGIN_DRIVE_LEVEL_6DB;
    logic [14:0] MARGIN_DRIVE_LEVEL_HALF_SWING, NOMINAL_DRIVE_LEVEL_3P5DB;
    int errors = 0;
    int tests_run = 0;

    always #2.5 SYS_CLK = ~SYS_CLK;

    eeprom_word_model eeprom (
        .clk(SYS_CLK),
        .word_valid(WORD_VALID),
        .word_addr(WORD_ADDR),
        .word_data(WORD_DATA),
        .load_done(LOAD_DONE)
    );

    eeprom_config_word_mapper DUT (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .WORD_VALID(WORD_VALID),
        .WORD_ADDR(WORD_ADDR),
        .WORD_DATA(WORD_DATA),
        .LOAD_DONE(LOAD_DONE),
        .CFG_READY(CFG_READY),
        .SUBSYS_VENDOR_ID(SUBSYS_VENDOR_ID),
        .SUBSYS_ID(SUBSYS_ID),
        .INT_PIN_REQ(INT_PIN_REQ),
        .MAX_PAYLOAD(MAX_PAYLOAD),
        .ASPM_SUPPORT(ASPM_SUPPORT),
        .ROLE_ERR_RPT(ROLE_ERR_RPT),
        .MSI_DISABLE(MSI_DISABLE),
        .COMPL_PARITY_DISABLE(COMPL_PARITY_DISABLE),
        .PM_CAP_DISABLE(PM_CAP_DISABLE),
        .POSTED_PASS_NONPOSTED_RULE(POSTED_PASS_NONPOSTED_RULE),
        .LINK_BW_NOTIFY(LINK_BW_NOTIFY),
        .ORDER_FROZEN(ORDER_FROZEN),
        .TX_SOF_LATENCY(TX_SOF_LATENCY),
        .SURPRISE_DOWN_EN(SURPRISE_DOWN_EN),
        .PM_DATA_SEL_RW(PM_DATA_SEL_RW),
        .LTR_EN(LTR_EN),
        .BOUNDARY_4KB_CHECK(BOUNDARY_4KB_CHECK),
        .MARGIN_DRIVE_LEVEL_3P5DB(MARGIN_DRIVE_LEVEL_3P5DB),
        .MARGIN_DRIVE_LEVEL_6DB(MARGIN_DRIVE_LEVEL_6DB),
        .MARGIN_DRIVE_LEVEL_HALF_SWING(MARGIN_DRIVE_LEVEL_HALF_SWING),
        .OBFF_EN(OBFF_EN),
        .NOMINAL_DRIVE_LEVEL_3P5DB(NOMINAL_DRIVE_LEVEL_3P5DB)
    );

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Expected port fields from the words last taken
    task automatic check_all(input logic [15:0] i, s, u, c, m, n,
                             input logic rdy);
        check(16'(INT_PIN_REQ), 16'({i[15], i[15], 1'b0}), "intpin");
        check(SUBSYS_VENDOR_ID, s, "subvendor");
        check(SUBSYS_ID, u, "subsys");
        check(16'(MAX_PAYLOAD), 16'({3{c[1:0]}}), "mps");
        check(16'(ASPM_SUPPORT), 16'({3{c[3:2]}}), "aspm");
        check(16'(ROLE_ERR_RPT), 16'({3{c[4]}}), "rber");
        check(16'(MSI_DISABLE), 16'({3{c[5]}}), "msi");
        check(16'(COMPL_PARITY_DISABLE), 16'({3{c[6]}}), "parity");
        check(16'(PM_CAP_DISABLE), 16'({3{c[7]}}), "pm");
        check(16'(POSTED_PASS_NONPOSTED_RULE), 16'({3{c[8]}}),
              "ppnp");
        check(16'(LINK_BW_NOTIFY), 16'({c[9], c[9], 1'b0}), "lbn");
        check(16'(ORDER_FROZEN), 16'({3{c[10]}}), "frozen");
        check(16'(TX_SOF_LATENCY), 16'({3{c[11]}}), "sof");
        check(16'(SURPRISE_DOWN_EN), 16'({3{c[12]}}), "sdown");
        check(16'(PM_DATA_SEL_RW), 16'({3{c[13]}}), "pmdata");
        check(16'(LTR_EN), 16'({3{c[14]}}), "ltr");
        check(16'(BOUNDARY_4KB_CHECK), 16'({3{c[15]}}), "4kb");
        check(16'(MARGIN_DRIVE_LEVEL_3P5DB), 16'({3{m[4:0]}}), "m35");
        check(16'(MARGIN_DRIVE_LEVEL_6DB), 16'({3{m[9:5]}}), "m6");
        check(16'(MARGIN_DRIVE_LEVEL_HALF_SWING), 16'({3{m[14:10]}}),
              "mh");
        check(16'(OBFF_EN), 16'({3{m[15]}}), "obff");
        check(16'(NOMINAL_DRIVE_LEVEL_3P5DB), 16'({3{n[4:0]}}),
              "nom");
        check(16'(CFG_READY), 16'(rdy), "ready");
    endtask

    task automatic apply_reset();
        @(posedge SYS_CLK);
        RSTN <= 1'b0;
        repeat (20) @(posedge SYS_CLK);
        #1;
        check_all(cfg_map_pkg::DEF_INT_PIN, cfg_map_pkg::DEF_SUBSYS,
                  cfg_map_pkg::DEF_SUBSYS, cfg_map_pkg::DEF_CAPS,
                  cfg_map_pkg::DEF_MARGIN, cfg_map_pkg::DEF_NOMINAL,
                  1'b0);
        @(posedge SYS_CLK);
        RSTN <= 1'b1;
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 40; n++) begin
            @(posedge SYS_CLK);
            #1;
            if (CFG_READY === 1'b1)
                return;
        end
        errors++;
        $display("[FAIL] t=%0t ready never rose", $time);
        give_verdict();
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        apply_reset();
        $display("test reset_defaults done");
        // Back to back, repeated and unknown addresses
        eeprom.put(8'h06, 16'h8000);
        eeprom.put(8'h08, 16'h1234);
        eeprom.put(8'h0a, 16'habcd);
        eeprom.put(8'h0c, 16'h0000);
        eeprom.put(8'h12, 16'hffff);
        eeprom.put(8'h0c, 16'h5a5a);
        eeprom.put(8'h0e, 16'he739);
        eeprom.put(8'h10, 16'hffd5);
        eeprom.run_load(0);
        wait_ready();
        check_all(16'h8000, 16'h1234, 16'habcd, 16'h5a5a, 16'he739,
                  16'hffd5, 1'b1);
        $display("test prompt_load done");
        // Words after the load has ended are ignored
        eeprom.put(8'h0c, 16'hffff);
        eeprom.put(8'h06, 16'h0000);
        eeprom.run_load(1);
        repeat (2) @(posedge SYS_CLK);
        #1;
        check_all(16'h8000, 16'h1234, 16'habcd, 16'h5a5a, 16'he739,
                  16'hffd5, 1'b1);
        $display("test late_words done");
        apply_reset();
        eeprom.put(8'h10, 16'h002a);
        eeprom.put(8'h0e, 16'h18c6);
        eeprom.put(8'h12, 16'h0000);
        eeprom.put(8'h0c, 16'ha5a5);
        eeprom.put(8'h0a, 16'h5432);
        eeprom.put(8'h08, 16'hedcb);
        eeprom.put(8'h06, 16'h7fff);
        eeprom.run_load(3);
        wait_ready();
        check_all(16'h7fff, 16'hedcb, 16'h5432, 16'ha5a5, 16'h18c6,
                  16'h002a, 1'b1);
        $display("test slow_reload done");
        give_verdict();
    end
endmodule

// ### sim/eeprom_word_model.sv
// Behavioural model of the serial configuration memory word stream
`timescale 1ns/1ps
module eeprom_word_model (
    input wire logic clk,
    output logic word_valid,
    output logic [cfg_map_pkg::ADDR_W-1:0] word_addr,
    output logic [cfg_map_pkg::WORD_W-1:0] word_data,
    output logic load_done
);
    // ----------------------------------------
    // Image of the words still to be sent
    // ----------------------------------------
    logic [cfg_map_pkg::ADDR_W-1:0] addr_list[$];
    logic [cfg_map_pkg::WORD_W-1:0] data_list[$];

    initial begin
        word_valid = 1'b0;
        word_addr = 8'h00;
        word_data = 16'h0000;
        load_done = 1'b0;
    end

    // ----------------------------------------
    // Stream access
    // ----------------------------------------
    task automatic put(input logic [7:0] a, input logic [15:0] d);
        addr_list.push_back(a);
        data_list.push_back(d);
    endtask

    // Released lines toggle so stale data never looks valid
    task automatic release_lines();
        word_valid <= 1'b0;
        load_done <= 1'b0;
        word_addr <= ~word_addr;
        word_data <= ~word_data;
    endtask

    // Gap of zero sends words back to back; last word ends the load
    task automatic run_load(input int gap);
        int i;
        for (i = 0; i < addr_list.size(); i++) begin
            @(posedge clk);
            word_valid <= 1'b1;
            word_addr <= addr_list[i];
            word_data <= data_list[i];
            load_done <= (i == addr_list.size() - 1);
            repeat (gap) begin
                @(posedge clk);
                release_lines();
            end
        end
        @(posedge clk);
        release_lines();
        addr_list.delete();
        data_list.delete();
    endtask
endmodule
